/* prs_pkg.sv */
// Constants and types for the power-on reset sequencer
package prs_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // Start-up times in ns; plain defaults, no silicon figures given
    localparam int BIAS_SETTLE_NS = 10_000;
    localparam int POWERUP_DELAY_NS = 1_000_000;
    localparam int XTAL_STARTUP_NS = 102_400;
    localparam int IOSC_STARTUP_NS = 10_000;
    localparam int RC_STARTUP_NS = 20_000;
    // Least times round up to whole cycles
    localparam int BIAS_CYC = (BIAS_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int POWERUP_TIMER_CYC = (POWERUP_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int XTAL_CYC = (XTAL_STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int IOSC_CYC = (IOSC_STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RC_CYC = (RC_STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 14;
    // Register word indices
    localparam logic [2:0] ADDR_RSTCTL = 3'h0;
    localparam logic [2:0] ADDR_RSTCTL2 = 3'h1;
    localparam logic [2:0] ADDR_RSTCTL3 = 3'h2;
    localparam logic [2:0] ADDR_OSCCFG = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    // Field positions
    localparam int BIT_BOR = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_TO = 3;
    localparam int BIT_PIN_RESET_FLAG = 7;
    localparam int BIT_VBEXIT = 0;
    localparam int BIT_BATTERY_POWERON_FLAG = 1;
    localparam int BIT_MAIN_SUPPLY_POWERON_FLAG = 2;
    // Reset values and the control write mask
    localparam logic [7:0] RSTCTL_RST = 8'h08;
    localparam logic [7:0] RSTCTL_WMASK = 8'h0B;
    localparam logic [7:0] RSTCTL3_RST = 8'h00;
    localparam logic [1:0] OSCCFG_RST = 2'h1;
    typedef enum logic [1:0] {
        OSC_XTAL = 2'h0,
        OSC_IOSC = 2'h1,
        OSC_RC = 2'h2
    } prs_osc_t;
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_BIAS = 3'h1,
        ST_POWERUP_TIMER = 3'h2,
        ST_OSC = 3'h3,
        ST_RUN = 3'h4,
        ST_VBAT = 3'h5,
        ST_HOLD = 3'h6
    } prs_state_t;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } prs_bus_req_t;
endpackage

/* prs_sequencer.sv */
// Power-on reset sequencer: reset causes, start-up delays, cause flags
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
//Contract
// [R1] Rising main supply makes a power-on pulse
// [R2] New pulse only after supply fell below rearm
// [R3] Pulse clears delay counter and forces reset
// [R4] Power-on loads clock source from configuration
// [R5] Bias settle delay precedes power-up timer
// [R6] Power-up timer delay blocks execution
// [R7] Power-on clears brown-out and power-on flags
// [R8] Hardware never sets power-on flag; software does
// [R9] Main-supply power-on flag set, software clears
// [R10] Clock start-up delay by source, then release
// [R11] Clock and execution only after all delays
// [R12] Battery monitor holds reset until battery good
// [R13] Battery power-on exit sets flag, registers init
// [R14] Battery mode: no execution, no power-up timer
// [R15] Supply return leaves battery mode, sets flag
// [R16] Low reset pin asserts system reset
// [R17] Pin release releases reset, vector fetch starts
// [R18] Pin reset keeps the current clock source
// [R19] Pin reset sets the pin reset flag
// [R20] Running watchdog timeout resets, clock kept
// [R21] Watchdog timeout in sleep only wakes
// [R22] Watchdog timeout clears its flag
module prs_sequencer #(
    parameter int POWERUP_TIMER_CYCLES = prs_pkg::POWERUP_TIMER_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic vdd_good,
    input wire logic vbat_good,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic cpu_sleep,
    input wire prs_pkg::prs_bus_req_t bus_req,
    output logic [7:0] rd_data_q,
    output logic system_reset_n_q,
    output logic clk_en_q,
    output logic [1:0] clk_sel_q,
    output logic vbat_mode_q,
    output logic wake_q,
    output logic reg_init_q,
    output logic keep_rtc_q
);
    import prs_pkg::*;

    // The delay counter must hold the longest power-up delay
    if (POWERUP_TIMER_CYCLES < 1 || POWERUP_TIMER_CYCLES >= (1 << CNT_W)) begin : g_powerup_timer_range
        $error("POWERUP_TIMER_CYCLES out of counter range");
    end

    // Pins cross from outside: three flops, the second and third are read
    logic vdd_m, vdd_s, vdd_p;
    logic vb_m, vb_s, vb_p;
    logic pin_m, pin_s, pin_p;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vdd_m <= 1'b0;
            vdd_s <= 1'b0;
            vdd_p <= 1'b0;
            // Battery taken as present so reset release gives no false exit edge
            vb_m <= 1'b1;
            vb_s <= 1'b1;
            vb_p <= 1'b1;
            pin_m <= 1'b1;
            pin_s <= 1'b1;
            pin_p <= 1'b1;
        end else begin
            vdd_m <= vdd_good;
            vdd_s <= vdd_m;
            vdd_p <= vdd_s;
            vb_m <= vbat_good;
            vb_s <= vb_m;
            vb_p <= vb_s;
            pin_m <= external_reset_pin_n;
            pin_s <= pin_m;
            pin_p <= pin_s;
        end
    end

    prs_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic armed_q;
    logic por_pulse, pin_fall, battery_poweron_flag_exit, wdt_rst;
    logic [CNT_W-1:0] osc_cnt;
    logic [7:0] rstctl_q, rstctl2_q, rstctl3_q;
    logic [1:0] osccfg_q;

    // Supply must drop below the rearm level before the next pulse
    assign por_pulse = vdd_s && !vdd_p && armed_q; // [R1] [R2]
    assign pin_fall = !pin_s && pin_p;
    assign battery_poweron_flag_exit = (st_q == ST_VBAT) && vb_s && !vb_p;
    assign wdt_rst = watchdog_timeout && !cpu_sleep && (st_q == ST_RUN);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b1;
        end else if (!vdd_s) begin
            armed_q <= 1'b1; // [R2]
        end else if (por_pulse) begin
            armed_q <= 1'b0;
        end
    end

    always_comb begin
        case (clk_sel_q)
            OSC_XTAL: osc_cnt = CNT_W'(XTAL_CYC - 1);
            OSC_IOSC: osc_cnt = CNT_W'(IOSC_CYC - 1);
            default: osc_cnt = CNT_W'(RC_CYC - 1);
        endcase
    end

    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        if (!vdd_s) begin
            st_d = ST_VBAT; // [R12] [R14]
        end else if (por_pulse) begin
            st_d = ST_BIAS; // [R3] [R5] [R15]
            cnt_d = CNT_W'(BIAS_CYC - 1);
        end else begin
            case (st_q)
                ST_BIAS: begin
                    if (cnt_q == '0) begin
                        st_d = ST_POWERUP_TIMER; // [R6]
                        cnt_d = CNT_W'(POWERUP_TIMER_CYCLES - 1);
                    end
                end
                ST_POWERUP_TIMER: begin
                    if (cnt_q == '0) begin
                        st_d = ST_OSC; // [R10]
                        cnt_d = osc_cnt;
                    end
                end
                ST_OSC: begin
                    if (cnt_q == '0) begin
                        st_d = pin_s ? ST_RUN : ST_HOLD; // [R10] [R11]
                    end
                end
                ST_RUN: begin
                    if (!pin_s || wdt_rst) begin
                        st_d = ST_HOLD; // [R16] [R20]
                    end
                end
                ST_HOLD: begin
                    if (pin_s) begin
                        st_d = ST_RUN; // [R17]
                    end
                end
                default: st_d = st_q;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_OFF;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Reset and clock outputs follow the next state so they leave a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            system_reset_n_q <= 1'b0;
            clk_en_q <= 1'b0;
            vbat_mode_q <= 1'b0;
        end else begin
            system_reset_n_q <= (st_d == ST_RUN); // [R11] [R16] [R17]
            clk_en_q <= (st_d == ST_RUN) || (st_d == ST_HOLD); // [R11] [R14]
            vbat_mode_q <= (st_d == ST_VBAT); // [R12]
        end
    end

    // Only a power-on reselects the clock; pin and watchdog resets keep it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_sel_q <= OSCCFG_RST;
        end else if (por_pulse) begin
            clk_sel_q <= osccfg_q; // [R4] [R18] [R20]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_q <= 1'b0;
            reg_init_q <= 1'b0;
            keep_rtc_q <= 1'b0;
        end else begin
            wake_q <= watchdog_timeout && cpu_sleep && (st_q == ST_RUN); // [R21]
            reg_init_q <= battery_poweron_flag_exit || por_pulse; // [R13] [R15]
            keep_rtc_q <= por_pulse && (st_q == ST_VBAT); // [R15]
        end
    end

    logic wr0, wr1, wr2, wr3;
    assign wr0 = bus_req.we && (bus_req.addr == ADDR_RSTCTL);
    assign wr1 = bus_req.we && (bus_req.addr == ADDR_RSTCTL2);
    assign wr2 = bus_req.we && (bus_req.addr == ADDR_RSTCTL3);
    assign wr3 = bus_req.we && (bus_req.addr == ADDR_OSCCFG);

    // Hardware events win over a write in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rstctl_q <= RSTCTL_RST;
        end else begin
            if (wr0) begin
                rstctl_q <= bus_req.wdata & RSTCTL_WMASK; // [R8] [R22]
            end
            if (por_pulse) begin
                rstctl_q[BIT_POR] <= 1'b0; // [R7]
                rstctl_q[BIT_BOR] <= 1'b0; // [R7]
                rstctl_q[BIT_TO] <= 1'b1;
            end
            if (watchdog_timeout && !por_pulse) begin
                rstctl_q[BIT_TO] <= 1'b0; // [R22]
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rstctl2_q <= 8'h00;
        end else begin
            if (wr1) begin
                rstctl2_q[BIT_PIN_RESET_FLAG] <= bus_req.wdata[BIT_PIN_RESET_FLAG];
            end
            if (pin_fall && vdd_s) begin
                rstctl2_q[BIT_PIN_RESET_FLAG] <= 1'b1; // [R19]
            end
        end
    end

    // Flags here are set by hardware and cleared by writing zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rstctl3_q <= RSTCTL3_RST;
        end else begin
            if (wr2) begin
                rstctl3_q[2:0] <= rstctl3_q[2:0] & bus_req.wdata[2:0]; // [R9]
            end
            if (por_pulse) begin
                rstctl3_q[BIT_MAIN_SUPPLY_POWERON_FLAG] <= 1'b1; // [R9]
            end
            if (battery_poweron_flag_exit) begin
                rstctl3_q[BIT_BATTERY_POWERON_FLAG] <= 1'b1; // [R13]
            end
            if (por_pulse && (st_q == ST_VBAT)) begin
                rstctl3_q[BIT_VBEXIT] <= 1'b1; // [R15]
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osccfg_q <= OSCCFG_RST;
        end else if (wr3) begin
            osccfg_q <= bus_req.wdata[1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
        end else if (bus_req.re) begin
            case (bus_req.addr)
                ADDR_RSTCTL: rd_data_q <= rstctl_q;
                ADDR_RSTCTL2: rd_data_q <= rstctl2_q;
                ADDR_RSTCTL3: rd_data_q <= rstctl3_q;
                ADDR_OSCCFG: rd_data_q <= {6'h00, osccfg_q};
                ADDR_STATUS: rd_data_q <= {1'b0, vbat_mode_q, clk_sel_q, 1'b0, st_q};
                default: rd_data_q <= 8'h00;
            endcase
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_bias_done;
        (st_q == ST_BIAS) && (cnt_q == '0) && vdd_s && !por_pulse;
    endsequence
    sequence s_osc_done;
        (st_q == ST_OSC) && (cnt_q == '0) && vdd_s && !por_pulse && pin_s;
    endsequence

    // A steady supply must never restart a running device
    property p_por_edge;
        (st_q == ST_RUN) && vdd_s && vdd_p |=> (st_q != ST_BIAS);
    endproperty
    a_por_edge: assert property (p_por_edge) else $error("pulse without rise"); // [R2]

    property p_por_enter;
        por_pulse |=> (st_q == ST_BIAS) && !system_reset_n_q && (cnt_q == BIAS_CYC - 1);
    endproperty
    a_por_enter: assert property (p_por_enter) else $error("pulse did not restart"); // [R3]

    property p_por_flags;
        por_pulse |=> (rstctl_q[1:0] == 2'h0) && rstctl3_q[BIT_MAIN_SUPPLY_POWERON_FLAG];
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong"); // [R7]

    property p_clk_sel;
        por_pulse |=> (clk_sel_q == $past(osccfg_q));
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock not reselected"); // [R4]

    property p_powerup_timer;
        s_bias_done |=> (st_q == ST_POWERUP_TIMER) && (cnt_q == POWERUP_TIMER_CYCLES - 1) && !clk_en_q;
    endproperty
    a_powerup_timer: assert property (p_powerup_timer) else $error("power-up timer not started"); // [R6]

    property p_release;
        s_osc_done |=> (st_q == ST_RUN) && system_reset_n_q && clk_en_q;
    endproperty
    a_release: assert property (p_release) else $error("reset not released"); // [R10]

    property p_pin_hold;
        (st_q == ST_RUN) && vdd_s && !por_pulse && !pin_s
            |=> !system_reset_n_q && $stable(clk_sel_q) && rstctl2_q[BIT_PIN_RESET_FLAG];
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin reset wrong"); // [R18]

    property p_wdt_sleep;
        watchdog_timeout && cpu_sleep && (st_q == ST_RUN) && vdd_s && !por_pulse && pin_s
            |=> wake_q && system_reset_n_q && !rstctl_q[BIT_TO];
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep timeout reset"); // [R21]

    property p_vbat;
        (st_q == ST_VBAT) && !vdd_s |=> !clk_en_q && !system_reset_n_q ##1 !clk_en_q;
    endproperty
    a_vbat: assert property (p_vbat) else $error("battery mode executes"); // [R14]

endmodule // prs_sequencer

/* prs_partner.sv */
// Supply monitors and reset pin driver facing the sequencer
`timescale 1ns/1ps
module prs_partner #(
    parameter int MIN_PULSE = 4
) (
    input wire logic clk,
    input wire logic vdd_on,
    input wire logic vbat_on,
    input wire logic pin_hold,
    output logic vdd_good,
    output logic vbat_good,
    output logic external_reset_pin_n = 1'b1
);
    int low_cnt = 0;
    // Supplies only ever rise after a drop, so every rise is a fresh event
    assign vdd_good = vdd_on;
    assign vbat_good = vbat_on;
    // A short request still yields the least pulse width on the pin
    always @(posedge clk) begin
        if (pin_hold || (low_cnt != 0 && low_cnt < MIN_PULSE)) begin
            external_reset_pin_n <= 1'b0;
            low_cnt <= low_cnt + 1;
        end else begin
            external_reset_pin_n <= 1'b1;
            low_cnt <= 0;
        end
    end
endmodule // prs_partner

/* power_on_reset_sequencer_tb.sv */
// Self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
module power_on_reset_sequencer_tb;
    import prs_pkg::*;
    localparam int PW = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic vdd_on = 1'b0;
    logic vbat_on = 1'b1;
    logic pin_hold = 1'b0;
    logic watchdog_timeout = 1'b0;
    logic cpu_sleep = 1'b0;
    prs_bus_req_t req = '0;
    logic vdd_good, vbat_good, pin_n, system_reset_n_q, clk_en_q, vbat_mode_q, wake_q;
    logic reg_init_q, keep_rtc_q;
    int init_n = 0;
    int keep_n = 0;
    logic [7:0] rd_data_q;
    logic [1:0] clk_sel_q, src;
    int bad_count = 0;
    int n_compared = 0;
    int i, s, n;

    always #50 clk = ~clk;

    // Pulses counted away from the launching edge
    always @(negedge clk) begin
        if (reg_init_q === 1'b1) init_n++;
        if (keep_rtc_q === 1'b1) keep_n++;
    end

    prs_partner prs_partner_inst (.clk(clk), .vdd_on(vdd_on), .vbat_on(vbat_on),
        .pin_hold(pin_hold), .vdd_good(vdd_good), .vbat_good(vbat_good),
        .external_reset_pin_n(pin_n));

    prs_sequencer #(.POWERUP_TIMER_CYCLES(PW)) prs_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
        .vdd_good(vdd_good), .vbat_good(vbat_good), .external_reset_pin_n(pin_n),
        .watchdog_timeout(watchdog_timeout), .cpu_sleep(cpu_sleep), .bus_req(req),
        .rd_data_q(rd_data_q), .system_reset_n_q(system_reset_n_q), .clk_en_q(clk_en_q),
        .clk_sel_q(clk_sel_q), .vbat_mode_q(vbat_mode_q), .wake_q(wake_q),
        .reg_init_q(reg_init_q), .keep_rtc_q(keep_rtc_q));

    task automatic wrap_up;
        $display("Counts: %0d compared, %0d mismatched", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 check(rd_data_q, exp, what);
    endtask

    // Bounded wait for the reset output to reach a level
    task automatic wait_rst(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while (system_reset_n_q !== lvl && cnt < bound) begin
            @(posedge clk);
            #1 cnt++;
        end
        if (cnt >= bound) begin
            bad_count++;
            $display("ERROR %0t reset wait ran out", $time);
            wrap_up();
        end
    endtask

    function automatic int start_cycles(input logic [1:0] sel);
        return BIAS_CYC + PW + (sel == 2'h0 ? XTAL_CYC : sel == 2'h1 ? IOSC_CYC : RC_CYC);
    endfunction

    task automatic power_up(input logic [1:0] sel);
        int e, c;
        e = start_cycles(sel);
        @(posedge clk);
        vdd_on <= 1'b1;
        @(posedge clk);
        #1 wait_rst(1'b1, e + 20, c);
        n_compared++;
        if (c < e || c > e + 8) begin
            bad_count++;
            $display("ERROR %0t start-up took %0d cycles, least %0d", $time, c, e);
        end
        check(8'(clk_en_q), 8'h01, "clock release");
        check(8'(clk_sel_q), 8'(sel), "source from config");
    endtask

    task automatic power_down;
        int c;
        @(posedge clk);
        vdd_on <= 1'b0;
        c = 0;
        while (vbat_mode_q !== 1'b1 && c < 10) begin
            @(posedge clk);
            #1 c++;
        end
        check(8'(vbat_mode_q), 8'h01, "battery mode");
        check(8'(system_reset_n_q), 8'h00, "reset in battery mode");
        if (vbat_mode_q !== 1'b1) wrap_up();
    endtask

    initial begin
        void'($urandom(32'hceaa1c0b));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        check(8'(system_reset_n_q), 8'h00, "reset before power");
        rchk(ADDR_RSTCTL, RSTCTL_RST, "ctl reset value");
        rchk(ADDR_RSTCTL2, 8'h00, "ctl2 reset value");
        rchk(ADDR_RSTCTL3, RSTCTL3_RST, "ctl3 reset value");
        rchk(ADDR_OSCCFG, {6'h00, OSCCFG_RST}, "osccfg reset value");
        wr(3'h5, 8'(($urandom() & 32'hFF) | 32'h1));
        rchk(3'h5, 8'h00, "unmapped");
        wr(ADDR_RSTCTL, 8'h0B);
        rchk(ADDR_RSTCTL, 8'h0B, "power-on flag set by software");
        $display("test registers done");
        s = $urandom_range(2);
        for (i = 0; i < 3; i++) begin
            src = 2'((s + i) % 3);
            wr(ADDR_OSCCFG, {6'h00, src});
            wr(ADDR_RSTCTL, 8'h0B);
            power_up(src);
            rchk(ADDR_RSTCTL, 8'h08, "power-on clears flags");
            rchk(ADDR_RSTCTL3, 8'h05, "supply flags");
            rchk(ADDR_STATUS, {2'h0, src, 1'h0, 3'h4}, "status in run");
            power_down();
        end
        $display("test power-on done");
        wr(ADDR_RSTCTL3, 8'h00);
        rchk(ADDR_RSTCTL3, 8'h00, "supply flags cleared");
        @(posedge clk);
        vbat_on <= 1'b0;
        repeat (6) @(posedge clk);
        vbat_on <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(ADDR_RSTCTL3, 8'h02, "battery power-on flag");
        check(8'(system_reset_n_q), 8'h00, "no execution in battery");
        check(8'(vbat_mode_q), 8'h01, "stays in battery");
        $display("test battery done");
        power_up(src);
        wr(ADDR_RSTCTL, 8'h0B);
        wr(ADDR_RSTCTL2, 8'h00);
        pin_hold <= 1'b1;
        wait_rst(1'b0, 10, n);
        pin_hold <= 1'b0;
        wait_rst(1'b1, 20, n);
        n_compared++;
        if (n > 10) begin
            bad_count++;
            $display("ERROR %0t pin release slow, %0d cycles", $time, n);
        end
        check(8'(clk_sel_q), 8'(src), "source kept after pin");
        rchk(ADDR_RSTCTL2, 8'h80, "pin reset flag");
        rchk(ADDR_RSTCTL, 8'h0B, "flags kept after pin");
        $display("test pin done");
        @(posedge clk);
        watchdog_timeout <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
        #1 wait_rst(1'b0, 3, n);
        check(8'(clk_sel_q), 8'(src), "source kept after watchdog");
        wait_rst(1'b1, 8, n);
        rchk(ADDR_RSTCTL, 8'h03, "watchdog flag cleared");
        wr(ADDR_RSTCTL, 8'h0B);
        cpu_sleep <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
        #1 check(8'(wake_q), 8'h01, "wake from sleep");
        repeat (4) begin
            @(posedge clk);
            #1 check(8'(system_reset_n_q), 8'h01, "no reset in sleep");
        end
        $display("test watchdog done");
        check(8'(init_n), 8'h05, "register init pulses");
        check(8'(keep_n), 8'h04, "calendar keep pulses");
        wrap_up();
    end
endmodule // power_on_reset_sequencer_tb
